//--- rtl/sample_cdc.sv
`default_nettype none

// Carries one measurement word from the front-end clock to the core clock
// with a two-phase toggle handshake.
module sample_cdc #(
	parameter int WIDTH = 64
) (
	// Front-end side
	input wire logic meas_clk,
	input wire logic sense_strobe,
	input wire logic [WIDTH-1:0] sense_data,
	// Core side
	input wire logic core_clk,
	input wire logic rst_n,
	output logic smp_valid,
	output logic [WIDTH-1:0] smp_data
);

	logic req_r;
	logic [WIDTH-1:0] hold_r;
	logic ack_s1_r, ack_s2_r;
	logic req_s1_r, req_s2_r, req_s3_r, ack_r;
	wire idle_w = (req_r == ack_s2_r);
	wire take_w = req_s2_r ^ req_s3_r;

	// --------------------------------------------------------------
	// Front-end domain
	// --------------------------------------------------------------
	// A strobe while the last word is unacknowledged is dropped; the
	// front end runs far faster than a detection period needs.
	always_ff @(posedge meas_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_r <= 1'b0;
			hold_r <= '0;
		end else if (sense_strobe && idle_w) begin
			req_r <= ~req_r;
			hold_r <= sense_data;
		end
	end

	// Acknowledge brought back to the front-end clock.
	always_ff @(posedge meas_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_s1_r <= 1'b0;
			ack_s2_r <= 1'b0;
		end else begin
			ack_s1_r <= ack_r;
			ack_s2_r <= ack_s1_r;
		end
	end

	// --------------------------------------------------------------
	// Core domain
	// --------------------------------------------------------------
	// The held word is stable whenever the synchronised toggle moves.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_s1_r <= 1'b0;
			req_s2_r <= 1'b0;
			req_s3_r <= 1'b0;
			ack_r <= 1'b0;
			smp_valid <= 1'b0;
			smp_data <= '0;
		end else begin
			req_s1_r <= req_r;
			req_s2_r <= req_s1_r;
			req_s3_r <= req_s2_r;
			ack_r <= req_s2_r;
			smp_valid <= take_w;
			if (take_w) begin
				smp_data <= hold_r;
			end
		end
	end

endmodule : sample_cdc

`default_nettype wire

//--- rtl/touch_defines.svh
`ifndef TOUCH_DEFINES_SVH
`define TOUCH_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define REG_TOUCH_CONFIGURATION 8'h00
`define REG_CHAN_ENABLE 8'h01
`define REG_BUTTON_ACTION_STATE 8'h02
`define REG_BUTTON_CHANGE_STATE 8'h03
`define REG_INTERRUPT_SETUP 8'h04

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CFG_SOFT_SDN_BIT 7
`define CFG_SENS_MSB 6
`define CFG_SENS_LSB 5
`define INT_ACLR_MSB 7
`define INT_ACLR_LSB 6
`define CHAN_EN_RESET 4'hf
`define CHAN_EN_UPPER 4'hf
`define SENS_INVALID 2'b11
`define ACLR_INVALID 2'b11

// ----------------------------------------------------------------------
// Detection thresholds in measurement steps
// ----------------------------------------------------------------------
`define THRESH_NORMAL 32
`define THRESH_HIGH 16
`define THRESH_LOW 64

// ----------------------------------------------------------------------
// Timing: figures in ms, counts derived from the core clock rate
// ----------------------------------------------------------------------
`define CLK_FREQ_KHZ 100000
`define DET_PERIOD_MS 16
`define CAL_PERIOD_MS 2000
`define AUTOCLR_SHORT_MS 8
`define AUTOCLR_LONG_MS 32
`define DET_CYCLES (`DET_PERIOD_MS * `CLK_FREQ_KHZ)
`define CAL_CYCLES (`CAL_PERIOD_MS * `CLK_FREQ_KHZ)
`define AUTOCLR_SHORT_CYCLES (`AUTOCLR_SHORT_MS * `CLK_FREQ_KHZ)
`define AUTOCLR_LONG_CYCLES (`AUTOCLR_LONG_MS * `CLK_FREQ_KHZ)

`endif

//--- rtl/touch_detect.sv
`include "touch_defines.svh"
`default_nettype none

// Notes on behaviour
// RULE_01: Sensitivity 00 normal, 01 high, 10 low; 11 never accepted.
// RULE_02: Each channel output pulls low while its channel is pressed.
// RULE_03: Offset 02h shows one pressed/released bit per channel.
// RULE_04: Offset 03h shows one touch-or-release event bit per channel.
// RULE_05: A validated change on any channel pulls the interrupt low.
// RULE_06: Any access to offset 03h returns the interrupt high.
// RULE_07: Auto-clear 00 off, 01 after 8 ms low, 10 after 32 ms; 11 invalid.
// RULE_08: Every 2 s the references are refreshed from measured values; the code skips channels that are pressed.
// RULE_09: Every 16 ms each channel is compared with its reference.
// RULE_10: A change counts only after two consecutive differing cycles.
// RULE_11: Change means above reference by over 32, 16 or 64 steps.
// RULE_12: Calibration absorbs drift; one-cycle disturbances are filtered.
// RULE_13: Shutdown keeps registers and stops all detection.
// RULE_14: Writing 1 to the configuration shutdown bit enters shutdown.
// RULE_15: Holding the shutdown pin low keeps the device shut down.
// RULE_16: The host reads offsets 02h and 03h after seeing the interrupt.
// RULE_17: Offset 01h holds per-channel enables, all enabled after reset.
// RULE_18: Reading offset 03h clears all change bits.
// RULE_19: A channel output is released after a validated release.
module touch_detect #(
	parameter int CAP_W = 16,
	parameter int DET_CYCLES = `DET_CYCLES,
	parameter int CAL_CYCLES = `CAL_CYCLES,
	parameter int AC_SHORT_CYCLES = `AUTOCLR_SHORT_CYCLES,
	parameter int AC_LONG_CYCLES = `AUTOCLR_LONG_CYCLES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Measurement front end
	input wire logic meas_clk,
	input wire logic sense_strobe,
	input wire logic [4*CAP_W-1:0] sense_input,
	// Register access from the serial slave
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Pins
	input wire logic shutdown_pin_n,
	output logic touch_irq_n,
	input wire logic [3:0] chan_out_i,
	output logic [3:0] chan_out_o,
	output logic [3:0] chan_out_oe
);
	import touch_pkg::*;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [CAP_W-1:0] thresh(input touch_pkg::sens_t s);
		unique case (s)
			SENS_HIGH: thresh = CAP_W'(`THRESH_HIGH);
			SENS_LOW: thresh = CAP_W'(`THRESH_LOW);
			default: thresh = CAP_W'(`THRESH_NORMAL);
		endcase
	endfunction : thresh

	// Only a rise above the reference counts as a touch.
	function automatic logic exceeds(input logic [CAP_W-1:0] m,
			input logic [CAP_W-1:0] r, input logic [CAP_W-1:0] t);
		exceeds = (m > r) && ((m - r) > t); // see RULE_11
	endfunction : exceeds

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic soft_shutdown_en_r;
	sens_t sens_r;
	logic [3:0] chan_enable_r;
	autoclr_t irq_autoclear_sel_r;
	logic [3:0] action_state_r, state_change_r, pend_r;
	logic [CAP_W-1:0] cur_r [4];
	logic [CAP_W-1:0] ref_r [4];
	logic have_smp_r, ref_ok_r;
	logic [31:0] det_cnt_r, cal_cnt_r, ac_cnt_r;
	logic sdn_s1_r, sdn_s2_r;
	logic smp_valid;
	logic [4*CAP_W-1:0] smp_data;

	// ------------------------------------------------------------------
	// Measurement crossing
	// ------------------------------------------------------------------
	sample_cdc #(.WIDTH(4*CAP_W)) u_cdc (
		.meas_clk(meas_clk),
		.sense_strobe(sense_strobe),
		.sense_data(sense_input),
		.core_clk(core_clk),
		.rst_n(rst_n),
		.smp_valid(smp_valid),
		.smp_data(smp_data)
	);

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	wire shut_w = soft_shutdown_en_r // see RULE_14
		| ~sdn_s2_r; // see RULE_15
	wire wr_cfg_w = reg_wr && (reg_addr == `REG_TOUCH_CONFIGURATION);
	wire wr_en_w = reg_wr && (reg_addr == `REG_CHAN_ENABLE);
	wire wr_int_w = reg_wr && (reg_addr == `REG_INTERRUPT_SETUP);
	wire hit_chg_w = reg_addr == `REG_BUTTON_CHANGE_STATE;
	wire rd_chg_w = reg_rd && hit_chg_w;
	wire acc_chg_w = (reg_rd || reg_wr) && hit_chg_w;
	wire [1:0] sens_in_w = reg_wdata[`CFG_SENS_MSB:`CFG_SENS_LSB];
	wire [1:0] aclr_in_w = reg_wdata[`INT_ACLR_MSB:`INT_ACLR_LSB];
	wire det_tick_w = (det_cnt_r == 32'(DET_CYCLES - 1)); // see RULE_09
	wire cal_tick_w = (cal_cnt_r == 32'(CAL_CYCLES - 1)); // see RULE_08
	wire det_go_w = det_tick_w && !shut_w && ref_ok_r; // see RULE_13
	wire cal_go_w = cal_tick_w && !shut_w && have_smp_r;
	wire [CAP_W-1:0] th_w = thresh(sens_r);
	logic [3:0] over_w;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			over_w[i] = exceeds(cur_r[i], ref_r[i], th_w);
		end
	end
	wire [3:0] diff_w = (over_w ^ action_state_r) & chan_enable_r;
	wire [3:0] evt_w = {4{det_go_w}} & diff_w & pend_r; // see RULE_10
	wire any_evt_w = |evt_w;
	wire ac_hit_w = ((irq_autoclear_sel_r == AUTOCLR_SHORT) &&
			(ac_cnt_r == 32'(AC_SHORT_CYCLES - 1))) ||
			((irq_autoclear_sel_r == AUTOCLR_LONG) &&
			(ac_cnt_r == 32'(AC_LONG_CYCLES - 1))); // see RULE_07
	wire [7:0] rd_mux_w =
		(reg_addr == `REG_TOUCH_CONFIGURATION) ?
			{soft_shutdown_en_r, sens_r, 5'h00} :
		(reg_addr == `REG_CHAN_ENABLE) ? {`CHAN_EN_UPPER, chan_enable_r} :
		(reg_addr == `REG_BUTTON_ACTION_STATE) ?
			{4'h0, action_state_r} : // see RULE_03
		(reg_addr == `REG_BUTTON_CHANGE_STATE) ?
			{4'h0, state_change_r} : // see RULE_04
		(reg_addr == `REG_INTERRUPT_SETUP) ?
			{irq_autoclear_sel_r, 6'h00} : 8'h00;

	// ------------------------------------------------------------------
	// Shutdown pin synchroniser
	// ------------------------------------------------------------------
	// Reset leaves the pin seen as high so a held-low pin shuts down
	// two edges after release.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sdn_s1_r <= 1'b1;
			sdn_s2_r <= 1'b1;
		end else begin
			sdn_s1_r <= shutdown_pin_n;
			sdn_s2_r <= sdn_s1_r;
		end
	end

	// ------------------------------------------------------------------
	// Registers written by software
	// ------------------------------------------------------------------
	// Invalid select codes are ignored so the old setting stays.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			soft_shutdown_en_r <= 1'b0;
			sens_r <= SENS_NORMAL;
			chan_enable_r <= `CHAN_EN_RESET; // see RULE_17
			irq_autoclear_sel_r <= AUTOCLR_OFF;
		end else begin
			if (wr_cfg_w) begin // see RULE_14
				soft_shutdown_en_r <= reg_wdata[`CFG_SOFT_SDN_BIT];
			end
			if (wr_cfg_w && sens_in_w != `SENS_INVALID) begin
				sens_r <= sens_t'(sens_in_w); // see RULE_01
			end
			if (wr_en_w) begin
				chan_enable_r <= reg_wdata[3:0]; // see RULE_17
			end
			if (wr_int_w && aclr_in_w != `ACLR_INVALID) begin // see RULE_07
				irq_autoclear_sel_r <= autoclr_t'(aclr_in_w);
			end
		end
	end

	// Read data is held until the next read.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux_w;
		end
	end

	// ------------------------------------------------------------------
	// Period timers, frozen during shutdown
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			det_cnt_r <= 32'h0;
			cal_cnt_r <= 32'h0;
		end else if (!shut_w) begin // see RULE_13
			det_cnt_r <= det_tick_w ? 32'h0 : det_cnt_r + 32'h1;
			cal_cnt_r <= cal_tick_w ? 32'h0 : cal_cnt_r + 32'h1;
		end
	end

	// ------------------------------------------------------------------
	// Samples and references
	// ------------------------------------------------------------------
	// The first sample after reset seeds the references. Later updates
	// skip pressed channels, so a long touch is not calibrated away.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			have_smp_r <= 1'b0;
			ref_ok_r <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				cur_r[i] <= '0;
				ref_r[i] <= '0;
			end
		end else begin
			if (smp_valid) begin
				have_smp_r <= 1'b1;
				for (int i = 0; i < 4; i++) begin
					cur_r[i] <= smp_data[i*CAP_W +: CAP_W];
				end
			end
			if (cal_go_w || (have_smp_r && !ref_ok_r)) begin
				ref_ok_r <= 1'b1;
				for (int i = 0; i < 4; i++) begin
					if (!ref_ok_r || !action_state_r[i]) begin
						ref_r[i] <= cur_r[i]; // see RULE_08 see RULE_12
					end
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Two-cycle validation and channel state
	// ------------------------------------------------------------------
	// A lone differing cycle only arms pend; a fast spike that is gone
	// by the next cycle clears it again and never reaches the outputs.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_r <= 4'h0;
			action_state_r <= 4'h0;
			chan_out_oe <= 4'h0;
			state_change_r <= 4'h0;
		end else begin
			if (det_go_w) begin
				pend_r <= diff_w & ~pend_r; // see RULE_10 see RULE_12
			end
			action_state_r <= action_state_r ^ evt_w; // see RULE_03
			chan_out_oe <= action_state_r ^ evt_w; // see RULE_02 see RULE_19
			// A new event beats the read-clear in the same cycle.
			state_change_r <= (rd_chg_w ? 4'h0 : state_change_r)
				| evt_w; // see RULE_04 see RULE_18
		end
	end

	// Open-drain channel pins only ever drive low.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_out_o <= 4'h0;
		end else begin
			chan_out_o <= 4'h0;
		end
	end

	// ------------------------------------------------------------------
	// Interrupt and auto-clear
	// ------------------------------------------------------------------
	// The timer restarts on every new event so each one gets a full
	// low period.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			touch_irq_n <= 1'b1;
			ac_cnt_r <= 32'h0;
		end else begin
			if (any_evt_w) begin
				touch_irq_n <= 1'b0; // see RULE_05
			end else if (acc_chg_w || ac_hit_w) begin
				touch_irq_n <= 1'b1; // see RULE_06 see RULE_07
			end
			if (touch_irq_n || any_evt_w ||
					irq_autoclear_sel_r == AUTOCLR_OFF) begin
				ac_cnt_r <= 32'h0;
			end else begin
				ac_cnt_r <= ac_cnt_r + 32'h1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence evt_s;
		any_evt_w;
	endsequence
	sequence chg_access_s;
		acc_chg_w && !any_evt_w;
	endsequence

	sens_code_legal_a: assert property ( // see RULE_01
		@(posedge core_clk) disable iff (!rst_n) sens_r != SENS_BAD)
		else $error("sensitivity holds the invalid code");
	out_tracks_press_a: assert property ( // see RULE_02
		@(posedge core_clk) disable iff (!rst_n)
		evt_s |=> (chan_out_oe == action_state_r) && (chan_out_oe ==
		$past(action_state_r ^ evt_w)))
		else $error("channel output does not follow press state");
	irq_on_event_a: assert property ( // see RULE_05
		@(posedge core_clk) disable iff (!rst_n)
		evt_s |=> !touch_irq_n && ((state_change_r & $past(evt_w)) ==
		$past(evt_w)))
		else $error("event did not pull interrupt low");
	irq_access_clear_a: assert property ( // see RULE_06
		@(posedge core_clk) disable iff (!rst_n)
		chg_access_s |=> touch_irq_n)
		else $error("interrupt still low after change register access");
	autoclr_off_hold_a: assert property ( // see RULE_07
		@(posedge core_clk) disable iff (!rst_n)
		!touch_irq_n && irq_autoclear_sel_r == AUTOCLR_OFF && !acc_chg_w
		|=> !touch_irq_n)
		else $error("interrupt released with auto-clear off");
	autoclear_release_a: assert property ( // see RULE_07
		@(posedge core_clk) disable iff (!rst_n)
		!touch_irq_n && ac_hit_w && !any_evt_w |=> touch_irq_n)
		else $error("auto-clear did not release interrupt");
	two_cycle_valid_a: assert property ( // see RULE_10
		@(posedge core_clk) disable iff (!rst_n)
		evt_s |-> ((pend_r & evt_w) == evt_w) && det_go_w)
		else $error("change accepted without previous differing cycle");
	shutdown_freeze_a: assert property ( // see RULE_13
		@(posedge core_clk) disable iff (!rst_n)
		shut_w |=> $stable(action_state_r) && $stable(pend_r) &&
		$stable(det_cnt_r))
		else $error("detection moved during shutdown");
	read_clears_chg_a: assert property ( // see RULE_18
		@(posedge core_clk) disable iff (!rst_n)
		reg_rd && hit_chg_w && !any_evt_w |=> state_change_r == 4'h0 ##0
		reg_rdata == {4'h0, $past(state_change_r)})
		else $error("change register read did not clear or report");

endmodule : touch_detect

`default_nettype wire

//--- rtl/touch_pkg.sv
`default_nettype none

package touch_pkg;

	// Sensitivity select encodings.
	typedef enum logic [1:0] {
		SENS_NORMAL = 2'b00,
		SENS_HIGH = 2'b01,
		SENS_LOW = 2'b10,
		SENS_BAD = 2'b11
	} sens_t;

	// Interrupt auto-clear select encodings.
	typedef enum logic [1:0] {
		AUTOCLR_OFF = 2'b00,
		AUTOCLR_SHORT = 2'b01,
		AUTOCLR_LONG = 2'b10,
		AUTOCLR_BAD = 2'b11
	} autoclr_t;

endpackage : touch_pkg

`default_nettype wire

//--- sim/sense_frontend.sv
`default_nettype none

// ----------------------------------------------------------------------
// Measurement front-end model
// ----------------------------------------------------------------------
// Sends all four channel counts as one word every GAP link clocks. A
// larger GAP models a slow converter. Between strobes the data lines
// carry the inverse of the current cap_level, so a late sample shows up as wrong.
module sense_frontend #(
	parameter int GAP = 10
) (
	// Link clock and reset
	input wire logic meas_clk,
	input wire logic rst_n,
	// Analog level seen by the converter
	input wire logic [63:0] cap_level,
	// Sample word towards the core
	output logic sense_strobe,
	output logic [63:0] sense_input
);
	timeunit 1ns;
	timeprecision 100ps;
	int gap_r;
	wire logic fire = (gap_r == GAP - 1);

	// Strobes stay GAP cycles apart, well over the handshake time.
	always_ff @(posedge meas_clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_r <= 0;
			sense_strobe <= 1'b0;
			sense_input <= '0;
		end else begin
			gap_r <= fire ? 0 : gap_r + 1;
			sense_strobe <= fire;
			sense_input <= fire ? cap_level : ~cap_level;
		end
	end
endmodule : sense_frontend

`default_nettype wire

//--- sim/testbench.sv
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [15:0] BASE = 16'h0400;
	localparam int TICK = 50;
	logic core_clk = 1'b0;
	logic meas_clk = 1'b0;
	logic rst_n, reg_wr, reg_rd, shutdown_pin_n, touch_irq_n, sense_strobe;
	logic [63:0] sense_input, level;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic [3:0] pin, o, oe;
	logic [1:0] sv [3] = '{2'b00, 2'b01, 2'b10};
	logic [1:0] av [3] = '{2'b01, 2'b10, 2'b00};
	int th [3] = '{32, 16, 64};
	int hold [3] = '{15, 55, 70};
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0;
	bit pr = 1'b0;

	// Open-drain pins with pull-ups: released pins read high.
	assign pin = (o & oe) | ~oe;

	always #5 core_clk = ~core_clk;
	initial begin
		#3.3;
		forever #16 meas_clk = ~meas_clk;
	end

	sense_frontend fe (.meas_clk(meas_clk), .rst_n(rst_n),
		.cap_level(level), .sense_strobe(sense_strobe),
		.sense_input(sense_input));

	touch_detect #(.DET_CYCLES(TICK), .CAL_CYCLES(20000),
		.AC_SHORT_CYCLES(20), .AC_LONG_CYCLES(60)) dut (
		.core_clk(core_clk), .rst_n(rst_n), .meas_clk(meas_clk),
		.sense_strobe(sense_strobe), .sense_input(sense_input),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.shutdown_pin_n(shutdown_pin_n), .touch_irq_n(touch_irq_n),
		.chan_out_i(pin), .chan_out_o(o), .chan_out_oe(oe));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Strobes rise and fall at falling edges, so one clear cycle follows.
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		v = reg_rdata;
		reg_rd = 1'b0;
	endtask : rd

	task automatic set_ch(input int c, input logic [15:0] v);
		@(negedge core_clk);
		level[c*16 +: 16] = v;
	endtask : set_ch

	task automatic ticks(input int n);
		repeat (n * TICK) @(negedge core_clk);
	endtask : ticks

	// Hangs are cut short by the cycle ceiling below.
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	// ------------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		shutdown_pin_n = 1'b1;
		level = {4{BASE}};
		repeat (20) @(negedge core_clk);
		rst_n = 1'b1;
		rd(8'h00, d); chk(d, 8'h00);
		rd(8'h01, d); chk(d, 8'hff);
		rd(8'h02, d); chk(d, 8'h00);
		rd(8'h03, d); chk(d, 8'h00);
		rd(8'h04, d); chk(d, 8'h00);
		rd(8'h05, d); chk(d, 8'h00);
		wr(8'h00, 8'h20);
		wr(8'h00, 8'h60);
		rd(8'h00, d); chk(d, 8'h20);
		wr(8'h04, 8'h40);
		wr(8'h04, 8'hc0);
		rd(8'h04, d); chk(d, 8'h40);
		// Auto-clear off again, or it would race the interrupt checks below.
		wr(8'h04, 8'h00);
		wr(8'h01, 8'h05);
		rd(8'h01, d); chk(d, 8'hf5);
		wr(8'h01, 8'h0f);
		wr(8'h02, 8'hff);
		rd(8'h02, d); chk(d, 8'h00);
		$display("test registers done");
		// Channel 0 sits exactly on the threshold, channel 1 one step over.
		for (int i = 0; i < 3; i++) begin
			wr(8'h00, {1'b0, sv[i], 5'h00});
			set_ch(0, BASE + 16'(th[i]));
			set_ch(1, BASE + 16'(th[i] + 1));
			ticks(4);
			rd(8'h02, d); chk(d, 8'h02);
			chk({4'h0, pin}, 8'h0d);
			chk({7'h0, touch_irq_n}, 8'h00);
			rd(8'h03, d); chk(d, 8'h02);
			chk({7'h0, touch_irq_n}, 8'h01);
			rd(8'h03, d); chk(d, 8'h00);
			set_ch(0, BASE);
			set_ch(1, BASE);
			ticks(4);
			rd(8'h02, d); chk(d, 8'h00);
			chk({4'h0, pin}, 8'h0f);
			rd(8'h03, d); chk(d, 8'h02);
		end
		$display("test sensitivity done");
		// A blip shorter than one detection period must be ignored.
		wr(8'h00, 8'h00);
		set_ch(1, BASE + 16'd100);
		repeat (20) @(negedge core_clk);
		set_ch(1, BASE);
		ticks(4);
		rd(8'h02, d); chk(d, 8'h00);
		chk({7'h0, touch_irq_n}, 8'h01);
		// A disabled channel must not react to a real press.
		wr(8'h01, 8'h0d);
		set_ch(1, BASE + 16'd100);
		ticks(4);
		rd(8'h02, d); chk(d, 8'h00);
		chk({7'h0, touch_irq_n}, 8'h01);
		set_ch(1, BASE);
		ticks(1);
		wr(8'h01, 8'h0f);
		$display("test glitch done");
		for (int i = 0; i < 3; i++) begin
			wr(8'h04, {av[i], 6'h00});
			set_ch(3, pr ? BASE : BASE + 16'd100);
			pr = !pr;
			for (int k = 0; k < 400 && touch_irq_n !== 1'b0; k++) begin
				@(negedge core_clk);
			end
			repeat (hold[i]) @(negedge core_clk);
			chk({7'h0, touch_irq_n}, 8'h00);
			repeat (10) @(negedge core_clk);
			if (i == 2) begin
				chk({7'h0, touch_irq_n}, 8'h00);
				wr(8'h03, 8'h00);
			end
			chk({7'h0, touch_irq_n}, 8'h01);
			rd(8'h03, d);
		end
		set_ch(3, BASE);
		ticks(4);
		rd(8'h03, d); chk(d, 8'h08);
		$display("test autoclear done");
		// Soft shutdown first, then the pin; both must freeze detection.
		for (int m = 0; m < 2; m++) begin
			if (m == 0) begin
				wr(8'h00, 8'h80);
			end else begin
				@(negedge core_clk);
				shutdown_pin_n = 1'b0;
			end
			set_ch(0, BASE + 16'd100);
			ticks(4);
			rd(8'h02, d); chk(d, 8'h00);
			chk({7'h0, touch_irq_n}, 8'h01);
			rd(8'h00, d); chk(d, m == 0 ? 8'h80 : 8'h00);
			if (m == 0) begin
				wr(8'h00, 8'h00);
			end else begin
				@(negedge core_clk);
				shutdown_pin_n = 1'b1;
			end
			ticks(4);
			rd(8'h02, d); chk(d, 8'h01);
			set_ch(0, BASE);
			ticks(4);
			rd(8'h03, d); chk(d, 8'h01);
		end
		$display("test shutdown done");
		// Drift under the threshold is absorbed by the next calibration.
		set_ch(2, BASE + 16'd30);
		// The calibration timer stood still through both shutdowns, so
		// wait well past its nominal point before moving channel 2 again.
		while (cyc < 21000) @(negedge core_clk);
		set_ch(2, BASE + 16'd50);
		ticks(4);
		rd(8'h02, d); chk(d, 8'h00);
		set_ch(2, BASE + 16'd63);
		ticks(4);
		rd(8'h02, d); chk(d, 8'h04);
		$display("test calibration done");
		report_and_stop();
	end
endmodule : testbench

`default_nettype wire
